// File: common/swb_map.svh
// offsets, reset values, ranges and timing figures of the sequencer
`ifndef SWB_MAP_SVH
`define SWB_MAP_SVH
// ------------------------------------------------------------
// parameter map offsets
// ------------------------------------------------------------
`define SWB_OFS_REL_DELAY 16'h050e
`define SWB_OFS_APP_DELAY 16'h0510
`define SWB_OFS_WIN_WIDTH 16'h0628
`define SWB_OFS_WIN_DWELL 16'h062a
`define SWB_OFS_NUDGE_SEL 16'h1410
`define SWB_OFS_CUR_TOTAL 16'h1e28
// ------------------------------------------------------------
// reset values and legal ranges
// ------------------------------------------------------------
`define SWB_RST_REL_DELAY 16'h0000
`define SWB_RST_APP_DELAY 16'h0064
`define SWB_RST_WIN_WIDTH 16'h001e
`define SWB_RST_WIN_DWELL 16'h0000
`define SWB_RST_NUDGE_SEL 16'h0001
`define SWB_MAX_DELAY 16'h03e8
`define SWB_MAX_DWELL 16'h3fff
`define SWB_MIN_WIDTH 16'h0001
// ------------------------------------------------------------
// timing: one delay unit is a millisecond
// ------------------------------------------------------------
`define SWB_MS_NS 1000000
`define SWB_CLK_NS 100
`define SWB_MS_CYCLES (`SWB_MS_NS / `SWB_CLK_NS)
`endif

// File: common/swb_pkg.sv
// types shared by the speed window and brake sequencer
`default_nettype none
package swb_pkg;
	// parameter map access from the fieldbus side
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} swb_par_req_t;
	// power stage sequence
	typedef enum logic [1:0] {
		SWB_OFF,
		SWB_RELEASE,
		SWB_ON,
		SWB_APPLY
	} swb_state_t;
endpackage : swb_pkg
`default_nettype wire

// File: design/swb_top.sv
// speed window monitor and holding brake sequencer
`include "swb_map.svh"
`default_nettype none
module swb_top import swb_pkg::*; #(
	parameter int TICK_CYCLES = `SWB_MS_CYCLES
) (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RESET,
	// parameter map
	input wire swb_par_req_t I_PAR_REQ,
	output logic [15:0] O_PAR_RDATA,
	output logic O_PAR_RVALID,
	// speed and current from the control loop
	input wire logic signed [15:0] I_SPEED_REF,
	input wire logic signed [15:0] I_SPEED_ACT,
	input wire logic [15:0] I_MOTOR_CURRENT,
	// stage command, panel and safety pin
	input wire logic I_STAGE_CMD,
	input wire logic I_HMI_BRAKE_RELEASE,
	input wire logic I_HMI_BRAKE_APPLY,
	input wire logic I_SAFE_OFF,
	// outputs to power stage and brake
	output logic O_SPEED_REACHED,
	output logic O_STAGE_ENABLE,
	output logic O_MOTOR_CURRENT_ON,
	output logic O_BRAKE_RELEASE,
	output logic O_BRAKE_REDUCE,
	output logic O_NUDGE
);
	// ------------------------------------------------------------
	// parameter registers
	// ------------------------------------------------------------
	logic [15:0] rel_delay_q, app_delay_q, width_q, dwell_q, nudge_q;
	logic [15:0] cur_q;
	wire wr = I_PAR_REQ.wr;
	wire [15:0] wd = I_PAR_REQ.wdata;
	wire hit_rel = I_PAR_REQ.addr == `SWB_OFS_REL_DELAY;
	wire hit_app = I_PAR_REQ.addr == `SWB_OFS_APP_DELAY;
	wire hit_wid = I_PAR_REQ.addr == `SWB_OFS_WIN_WIDTH;
	wire hit_dwl = I_PAR_REQ.addr == `SWB_OFS_WIN_DWELL;
	wire hit_ndg = I_PAR_REQ.addr == `SWB_OFS_NUDGE_SEL;
	wire hit_cur = I_PAR_REQ.addr == `SWB_OFS_CUR_TOTAL;
	// out of range values are dropped so a setting never leaves its range
	wire wr_rel = wr && hit_rel && wd <= `SWB_MAX_DELAY;
	wire wr_app = wr && hit_app && wd <= `SWB_MAX_DELAY;
	wire wr_wid = wr && hit_wid && wd >= `SWB_MIN_WIDTH;
	wire wr_dwl = wr && hit_dwl && wd <= `SWB_MAX_DWELL;
	wire wr_ndg = wr && hit_ndg && wd <= 16'h0001;
	wire dwell_chg = wr_dwl && wd != dwell_q;
	wire [15:0] rd_mux = hit_rel ? rel_delay_q :
		hit_app ? app_delay_q :
		hit_wid ? width_q :
		hit_dwl ? dwell_q :
		hit_ndg ? nudge_q :
		hit_cur ? cur_q : 16'h0000;

	// settings keep their default until a legal write
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			rel_delay_q <= `SWB_RST_REL_DELAY;
			app_delay_q <= `SWB_RST_APP_DELAY;
			width_q <= `SWB_RST_WIN_WIDTH;
			dwell_q <= `SWB_RST_WIN_DWELL;
			nudge_q <= `SWB_RST_NUDGE_SEL;
		end else begin
			if (wr_rel) rel_delay_q <= wd;
			if (wr_app) app_delay_q <= wd;
			if (wr_wid) width_q <= wd;
			if (wr_dwl) dwell_q <= wd;
			if (wr_ndg) nudge_q <= wd;
		end
	end

	// read answer one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			O_PAR_RDATA <= 16'h0000;
			O_PAR_RVALID <= 1'b0;
			cur_q <= 16'h0000;
		end else begin
			O_PAR_RVALID <= I_PAR_REQ.rd;
			if (I_PAR_REQ.rd) O_PAR_RDATA <= rd_mux;
			cur_q <= I_MOTOR_CURRENT;
		end
	end

	// ------------------------------------------------------------
	// millisecond tick
	// ------------------------------------------------------------
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	logic [15:0] tick_cnt_q;
	logic tick_q;
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_cnt_q == TICK_LAST;
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 16'h0000 :
				tick_cnt_q + 16'h0001;
		end
	end

	// ------------------------------------------------------------
	// speed window monitor
	// ------------------------------------------------------------
	logic [15:0] win_cnt_q;
	wire signed [16:0] diff = 17'(I_SPEED_ACT) - 17'(I_SPEED_REF);
	wire [16:0] adiff = diff[16] ? 17'(-diff) : 17'(diff);
	wire in_band = adiff <= {1'b0, width_q};
	wire mon_on = dwell_q != 16'h0000;
	wire restart = dwell_chg || !in_band || !mon_on;
	wire reached_d = !restart && (win_cnt_q >= dwell_q);

	// dwell counter counts ms ticks seen while in band
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			win_cnt_q <= 16'h0000;
			O_SPEED_REACHED <= 1'b0;
		end else begin
			if (restart) win_cnt_q <= 16'h0000;
			else if (tick_q && win_cnt_q < dwell_q)
				win_cnt_q <= win_cnt_q + 16'h0001;
			O_SPEED_REACHED <= reached_d;
		end
	end

	// ------------------------------------------------------------
	// brake and power stage sequencer
	// ------------------------------------------------------------
	logic safe_meta_q, safe_q;
	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			safe_meta_q <= 1'b0;
			safe_q <= 1'b0;
		end else begin
			safe_meta_q <= I_SAFE_OFF;
			safe_q <= safe_meta_q;
		end
	end

	swb_state_t state_q, state_d;
	logic [15:0] dly_q, dly_d;
	logic man_rel_q;
	wire dly_done = dly_q == 16'h0000;
	wire dly_step = tick_q && !dly_done;
	// panel commands only count while the stage is off
	wire man_ok = state_q == SWB_OFF;

	// next state; the safety path wins over every other cause
	always_comb begin
		state_d = state_q;
		dly_d = dly_step ? dly_q - 16'h0001 : dly_q;
		if (safe_q) begin
			state_d = SWB_OFF;
			dly_d = 16'h0000;
		end else begin
			case (state_q)
				SWB_OFF: begin
					if (I_STAGE_CMD) begin
						state_d = SWB_RELEASE;
						dly_d = rel_delay_q;
					end
				end
				SWB_RELEASE: begin
					if (!I_STAGE_CMD) state_d = SWB_OFF;
					else if (dly_done) state_d = SWB_ON;
				end
				SWB_ON: begin
					if (!I_STAGE_CMD) begin
						state_d = SWB_APPLY;
						dly_d = app_delay_q;
					end
				end
				SWB_APPLY: begin
					if (dly_done) state_d = SWB_OFF;
				end
				default: state_d = SWB_OFF;
			endcase
		end
	end

	// outputs are registered from the next state so they move with it
	wire stage_d = state_d == SWB_ON;
	wire current_d = state_d == SWB_ON || state_d == SWB_APPLY;
	wire brake_d = state_d == SWB_RELEASE || state_d == SWB_ON ||
		(state_d == SWB_OFF && state_q == SWB_OFF && man_rel_q);

	always_ff @(posedge I_CLOCK or posedge I_RESET) begin
		if (I_RESET) begin
			state_q <= SWB_OFF;
			dly_q <= 16'h0000;
			man_rel_q <= 1'b0;
			O_STAGE_ENABLE <= 1'b0;
			O_MOTOR_CURRENT_ON <= 1'b0;
			O_BRAKE_RELEASE <= 1'b0;
			O_BRAKE_REDUCE <= 1'b0;
			O_NUDGE <= 1'b0;
		end else begin
			state_q <= state_d;
			dly_q <= dly_d;
			// a manual release is forgotten once the sequence takes over
			if (!man_ok) man_rel_q <= 1'b0;
			else if (I_HMI_BRAKE_APPLY) man_rel_q <= 1'b0;
			else if (I_HMI_BRAKE_RELEASE) man_rel_q <= 1'b1;
			O_STAGE_ENABLE <= stage_d;
			O_MOTOR_CURRENT_ON <= current_d;
			O_BRAKE_RELEASE <= brake_d;
			O_BRAKE_REDUCE <= 1'b0; // no reduced hold voltage
			O_NUDGE <= stage_d && state_q != SWB_ON && nudge_q[0];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	reach_dwell_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$rose(O_SPEED_REACHED) |-> $past(in_band) && $past(win_cnt_q) == $past(dwell_q))
		else $error("speed reached before dwell elapsed");
	width_range_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		wr && hit_wid && wd == 16'h0000 |=> width_q == $past(width_q))
		else $error("band width took zero");
	dwell_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		dwell_q == 16'h0000 |=> !O_SPEED_REACHED)
		else $error("speed reached with monitor off");
	dwell_write_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		dwell_chg |=> !O_SPEED_REACHED && win_cnt_q == 16'h0000)
		else $error("dwell change did not restart monitor");
	release_wait_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$rose(O_STAGE_ENABLE) |-> O_BRAKE_RELEASE && $past(state_q) == SWB_RELEASE
		&& $past(dly_q) == 16'h0000)
		else $error("stage enabled before release delay");
	manual_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$rose(man_rel_q) |-> !O_STAGE_ENABLE && $past(state_q) == SWB_OFF)
		else $error("manual brake taken with stage on");
	nudge_pulse_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$rose(O_STAGE_ENABLE) |-> O_NUDGE == nudge_q[0] ##1 !O_NUDGE)
		else $error("nudge wrong at activation");
	brake_apply_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$fell(O_STAGE_ENABLE) |-> !O_BRAKE_RELEASE)
		else $error("brake not engaged at disable");
	current_hold_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		$fell(O_STAGE_ENABLE) && !$past(safe_q) |-> O_MOTOR_CURRENT_ON)
		else $error("current dropped before apply delay");
	safe_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		safe_q |=> !O_MOTOR_CURRENT_ON && !O_STAGE_ENABLE && !O_BRAKE_RELEASE)
		else $error("safe off did not remove current");
	full_volt_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		O_BRAKE_RELEASE |-> !O_BRAKE_REDUCE)
		else $error("brake voltage reduced");
	band_leave_a: assert property (@(posedge I_CLOCK) disable iff (I_RESET)
		!in_band |=> !O_SPEED_REACHED && win_cnt_q == 16'h0000)
		else $error("band exit did not clear");
endmodule : swb_top
`default_nettype wire

// File: bench/swb_motor_model.sv
// behavioural power stage and motor current feedback for the sequencer
`default_nettype none
module swb_motor_model #(
	parameter logic [15:0] RUN_CURRENT = 16'h00c8
) (
	// controls from the sequencer
	input wire logic i_current_on,
	input wire logic i_stage_enable,
	// total current fed back to the drive
	output logic [15:0] o_current
);
	timeunit 1ns;
	timeprecision 1ns;
	// current flows while the stage or the hold current is on
	assign o_current = (i_current_on || i_stage_enable) ? RUN_CURRENT : 16'h0000;
endmodule : swb_motor_model
`default_nettype wire

// File: bench/swb_top_tb_top.sv
// self-checking bench for the speed window and brake sequencer
`default_nettype none
module swb_top_tb_top import swb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// short ms tick keeps the delays quick to simulate
	localparam int T = 4;
	typedef struct packed {logic wr; logic [15:0] a, d, e;} swb_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	swb_par_req_t req = '0;
	logic signed [15:0] sref = 16'sd1000;
	logic signed [15:0] sact = 16'sd1010;
	logic cmd = 1'b0;
	logic hrel = 1'b0;
	logic happ = 1'b0;
	logic soff = 1'b0;
	logic [15:0] rdat, cur;
	logic rvld, rch, ena, con, brel, bred, ndg;
	// outputs the bounded wait can watch: 0 reached, 1 stage, 2 current
	wire [2:0] obs = {con, ena, rch};
	int n_mismatch = 0;
	int cmp_count = 0;
	int n;
	swb_row_t rows [14];
	always #50 clk = ~clk;
	swb_top #(.TICK_CYCLES(T)) u_swb_top (.I_CLOCK(clk), .I_RESET(rst),
		.I_PAR_REQ(req), .O_PAR_RDATA(rdat), .O_PAR_RVALID(rvld),
		.I_SPEED_REF(sref), .I_SPEED_ACT(sact), .I_MOTOR_CURRENT(cur),
		.I_STAGE_CMD(cmd), .I_HMI_BRAKE_RELEASE(hrel),
		.I_HMI_BRAKE_APPLY(happ), .I_SAFE_OFF(soff),
		.O_SPEED_REACHED(rch), .O_STAGE_ENABLE(ena),
		.O_MOTOR_CURRENT_ON(con), .O_BRAKE_RELEASE(brel),
		.O_BRAKE_REDUCE(bred), .O_NUDGE(ndg));
	swb_motor_model u_swb_motor_model (.i_current_on(con),
		.i_stage_enable(ena), .o_current(cur));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#10;
	endtask : cyc
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_sim
	// one request, then a quiet cycle so strobes never retrigger
	task bus(input logic w, input logic [15:0] a, input logic [15:0] d);
		req = '{w, ~w, a, d};
		cyc(1);
		chk({15'h0, rvld}, {15'h0, ~w});
		req = '0;
		cyc(1);
	endtask : bus
	// bounded wait on one output; running out ends the run
	task wt(input int b, input logic v, input int lim);
		n = 0;
		while (obs[b] !== v && n < lim) begin
			cyc(1);
			n++;
		end
		if (n >= lim) begin
			n_mismatch++;
			$display("[FAIL] %0t wait ran out", $time);
			end_sim();
		end
	endtask : wt
	task in_rng(input int lo, input int hi);
		chk({15'h0, n >= lo && n <= hi}, 16'h0001);
	endtask : in_rng
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rows = '{{1'b0, 16'h050e, 16'h0, 16'h0}, {1'b0, 16'h0510, 16'h0, 16'h64},
			{1'b0, 16'h0628, 16'h0, 16'h1e}, {1'b0, 16'h062a, 16'h0, 16'h0},
			{1'b0, 16'h1410, 16'h0, 16'h1}, {1'b0, 16'h0002, 16'h0, 16'h0},
			{1'b1, 16'h050e, 16'h3e9, 16'h0}, {1'b1, 16'h0628, 16'h0, 16'h1e},
			{1'b1, 16'h062a, 16'h4000, 16'h0}, {1'b1, 16'h1410, 16'h2, 16'h1},
			{1'b1, 16'h0510, 16'h2, 16'h2}, {1'b1, 16'h0628, 16'hffff, 16'hffff},
			{1'b1, 16'h0628, 16'h1e, 16'h1e}, {1'b1, 16'h1e28, 16'h1234, 16'h0}};
		cyc(2);
		rst = 1'b0;
		chk({10'h0, rch, ena, con, brel, bred, ndg}, 16'h0);
		for (int i = 0; i < 14; i++) begin
			if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 16'h0);
			chk(rdat, rows[i].e);
		end
		$display("register table done");
		// dwell zero keeps the monitor off, then a 3 ms dwell
		cyc(20);
		chk({15'h0, rch}, 16'h0);
		bus(1'b1, 16'h062a, 16'h3);
		wt(0, 1'b1, 5 * T);
		in_rng(2 * T - 2, 3 * T + 3);
		sact = 16'sd1031;
		cyc(2);
		chk({15'h0, rch}, 16'h0);
		sact = 16'sd970;
		wt(0, 1'b1, 5 * T);
		in_rng(2 * T - 1, 3 * T + 3);
		bus(1'b1, 16'h062a, 16'h5);
		chk({15'h0, rch}, 16'h0);
		$display("speed window done");
		// panel brake release while the stage is off, panel apply ignored while it is on, then a normal disable
		hrel = 1'b1;
		cyc(2);
		hrel = 1'b0;
		chk({15'h0, brel}, 16'h1);
		cmd = 1'b1;
		cyc(1);
		chk({15'h0, brel}, 16'h1);
		cyc(1);
		chk({12'h0, ena, con, bred, ndg}, 16'hd);
		happ = 1'b1;
		cyc(2);
		happ = 1'b0;
		chk({15'h0, brel}, 16'h1);
		bus(1'b0, 16'h1e28, 16'h0);
		chk(rdat, 16'h00c8);
		cmd = 1'b0;
		cyc(1);
		chk({13'h0, ena, brel, con}, 16'h1);
		wt(2, 1'b0, 4 * T);
		in_rng(T - 2, 2 * T + 3);
		$display("normal disable done");
		// release delay of 2 ms with nudge off, then safe torque off
		bus(1'b1, 16'h050e, 16'h2);
		bus(1'b1, 16'h1410, 16'h0);
		cmd = 1'b1;
		wt(1, 1'b1, 5 * T);
		in_rng(T, 2 * T + 4);
		chk({15'h0, ndg}, 16'h0);
		soff = 1'b1;
		cyc(3);
		chk({13'h0, ena, con, brel}, 16'h0);
		cmd = 1'b0;
		soff = 1'b0;
		cyc(4);
		$display("safe off done");
		end_sim();
	end
endmodule : swb_top_tb_top
`default_nettype wire
